// ### design/dlg_gain_select.sv
// Pre/post sync gain selection for one feedback loop
`timescale 1ns/1ps
module dlg_gain_select
  import dlg_pkg::*;
(
  input wire logic [1:0] pre_code_i,
  input wire logic post_half_i,
  input wire logic after_sync_i,
  output logic [GAIN_W-1:0] gain_o
);
  logic [GAIN_W-1:0] pre_gain;

  always_comb begin
    // Code n selects n+1 times base, i.e. 2n+2 half units
    pre_gain = GAIN_W'({pre_code_i, 1'b0}) + GAIN_W'(2);
    if (after_sync_i && post_half_i) begin
      gain_o = GAIN_HALF;
    end else begin
      gain_o = pre_gain;
    end
  end
endmodule : dlg_gain_select

// ### design/dlg_loop_config.sv
// Demodulator loop gain configuration registers and pre/post sync gain steering
`timescale 1ns/1ps
// What this block does
// - Gate bit freezes both loops until carrier.
// - Pre-sync frequency gain code selects K to 4K.
// - Post-sync frequency gain: pre-sync value or K/2.
// - Saturation code limits offset; zero disables.
// - Pre-sync integral code selects one to four times.
// - Pre-sync proportional code selects one to four times.
// - Post-sync integral bit sets integral gain after sync.
// - Post-sync integral: pre-sync value or half.
module dlg_loop_config
  import dlg_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic [DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [DATA_W-1:0] reg_rdata_o,
  input wire logic rx_start_i,
  input wire logic sync_match_i,
  input wire logic carrier_sense_i,
  output logic loops_frozen_o,
  output logic after_sync_o,
  output logic [GAIN_W-1:0] freq_gain_o,
  output logic freq_comp_enable_o,
  output logic [1:0] freq_limit_shift_o,
  output logic [GAIN_W-1:0] clkrec_integral_gain_o,
  output logic [GAIN_W-1:0] clkrec_proportional_gain_o,
  output logic [1:0] bit_sync_low_bits_o
);
  logic [DATA_W-1:0] freq_offset_comp_config;
  logic [DATA_W-1:0] bit_sync_config;
  logic [DATA_W-1:0] rdata;
  logic sync_found;
  logic carrier_seen;
  logic [DATA_W-1:0] next_freq_offset_comp_config;
  logic [DATA_W-1:0] next_bit_sync_config;
  logic [DATA_W-1:0] next_rdata;
  logic next_sync_found;
  logic next_carrier_seen;
  logic after_sync;
  logic loop_freeze_until_carrier;
  logic [1:0] freq_offset_saturation;
  logic carrier_present;
  // Address decode and per-bit write enables
  logic sel_freq_cfg;
  logic sel_bit_sync;
  logic wr_freq_cfg;
  logic wr_bit_sync;
  logic [DATA_W-1:0] freq_cfg_wmask;
  logic [DATA_W-1:0] bit_sync_wmask;
  logic [DATA_W-1:0] read_mux;
  // Field views of the two registers
  logic [1:0] freq_gain_before_sync;
  logic freq_gain_after_sync;
  logic [1:0] clkrec_integral_before_sync;
  logic [1:0] clkrec_proportional_before_sync;
  logic clkrec_integral_after_sync;

  // Address decode for the write path; the read path decodes reg_addr_i in its own case
  assign sel_freq_cfg = reg_addr_i == FREQ_OFFSET_COMP_CONFIG_ADDR;
  assign sel_bit_sync = reg_addr_i == BIT_SYNC_CONFIG_ADDR;
  assign wr_freq_cfg = reg_wr_i & sel_freq_cfg;
  assign wr_bit_sync = reg_wr_i & sel_bit_sync;

  // Per-bit write enables; unused bits never open, so they keep their reset zero
  for (genvar gi = 0; gi < DATA_W; gi++) begin : g_wmask
    assign freq_cfg_wmask[gi] = wr_freq_cfg & FREQ_OFFSET_COMP_CONFIG_MASK[gi];
    assign bit_sync_wmask[gi] = wr_bit_sync & BIT_SYNC_CONFIG_MASK[gi];
  end

  // Read path
  always_comb begin
    unique case (reg_addr_i)
      FREQ_OFFSET_COMP_CONFIG_ADDR: read_mux = freq_offset_comp_config;
      BIT_SYNC_CONFIG_ADDR: read_mux = bit_sync_config;
      default: read_mux = UNMAPPED_READ;
    endcase
  end

  // Register file; a read in the same cycle as a write returns the old value
  always_comb begin
    next_freq_offset_comp_config = freq_offset_comp_config & ~freq_cfg_wmask;
    next_freq_offset_comp_config = next_freq_offset_comp_config | (reg_wdata_i & freq_cfg_wmask);
    next_bit_sync_config = bit_sync_config & ~bit_sync_wmask;
    next_bit_sync_config = next_bit_sync_config | (reg_wdata_i & bit_sync_wmask);
  end

  // Configuration registers
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      freq_offset_comp_config <= FREQ_OFFSET_COMP_CONFIG_RST;
      bit_sync_config <= BIT_SYNC_CONFIG_RST;
    end else begin
      freq_offset_comp_config <= next_freq_offset_comp_config;
      bit_sync_config <= next_bit_sync_config;
    end
  end

  // Read data holds between reads, so a slow host may fetch it late
  always_comb begin
    next_rdata = rdata;
    if (reg_rd_i) begin
      next_rdata = read_mux;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rdata <= UNMAPPED_READ;
    end else begin
      rdata <= next_rdata;
    end
  end

  assign reg_rdata_o = rdata;

  // Sync state: a match in the start cycle is kept, so no event is lost
  always_comb begin
    next_sync_found = sync_found;
    if (rx_start_i) begin
      next_sync_found = 1'b0;
    end
    if (sync_match_i) begin
      next_sync_found = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      sync_found <= 1'b0;
    end else begin
      sync_found <= next_sync_found;
    end
  end

  // Carrier state: a carrier in the start cycle wins over the clear
  always_comb begin
    next_carrier_seen = carrier_seen;
    if (rx_start_i) begin
      next_carrier_seen = 1'b0;
    end
    if (carrier_sense_i) begin
      next_carrier_seen = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      carrier_seen <= 1'b0;
    end else begin
      carrier_seen <= next_carrier_seen;
    end
  end

  // Match takes effect in its own cycle; the flag only holds it afterwards
  assign after_sync = sync_found | sync_match_i;
  assign after_sync_o = after_sync;

  assign loop_freeze_until_carrier = freq_offset_comp_config[LOOP_FREEZE_UNTIL_CARRIER_BIT];
  // Live carrier unfreezes at once; the seen flag keeps loops running if it drops
  assign carrier_present = carrier_seen | carrier_sense_i;
  assign loops_frozen_o = loop_freeze_until_carrier & ~carrier_present;

  assign freq_gain_before_sync = freq_offset_comp_config[FREQ_GAIN_BEFORE_SYNC_LSB +: 2];
  assign freq_gain_after_sync = freq_offset_comp_config[FREQ_GAIN_AFTER_SYNC_BIT];
  assign clkrec_integral_before_sync = bit_sync_config[CLKREC_INTEGRAL_BEFORE_SYNC_LSB +: 2];
  assign clkrec_proportional_before_sync =
    bit_sync_config[CLKREC_PROPORTIONAL_BEFORE_SYNC_LSB +: 2];
  assign clkrec_integral_after_sync = bit_sync_config[CLKREC_INTEGRAL_AFTER_SYNC_BIT];

  dlg_gain_select u_freq_gain (
    .pre_code_i(freq_gain_before_sync),
    .post_half_i(freq_gain_after_sync),
    .after_sync_i(after_sync),
    .gain_o(freq_gain_o)
  );

  dlg_gain_select u_integral_gain (
    .pre_code_i(clkrec_integral_before_sync),
    .post_half_i(clkrec_integral_after_sync),
    .after_sync_i(after_sync),
    .gain_o(clkrec_integral_gain_o)
  );

  // Post-sync proportional choice lives in bits below this block, so no half step here
  dlg_gain_select u_proportional_gain (
    .pre_code_i(clkrec_proportional_before_sync),
    .post_half_i(1'b0),
    .after_sync_i(after_sync),
    .gain_o(clkrec_proportional_gain_o)
  );

  assign freq_offset_saturation = freq_offset_comp_config[FREQ_OFFSET_SATURATION_LSB +: 2];
  // No modulation check here: software must clear saturation for ASK/OOK
  assign freq_comp_enable_o = freq_offset_saturation != SAT_OFF;

  always_comb begin
    unique case (freq_offset_saturation)
      2'h0: begin
        freq_limit_shift_o = SAT_OFF;
      end
      2'h1: begin
        freq_limit_shift_o = SAT_SHIFT_CODE1;
      end
      2'h2: begin
        freq_limit_shift_o = SAT_SHIFT_CODE2;
      end
      2'h3: begin
        freq_limit_shift_o = SAT_SHIFT_CODE3;
      end
    endcase
  end

  assign bit_sync_low_bits_o = bit_sync_config[1:0];
endmodule : dlg_loop_config

// ### design/dlg_pkg.sv
// Package: register map, field positions and reset values for the loop gain configuration
package dlg_pkg;
  localparam int unsigned ADDR_W = 6;
  localparam int unsigned DATA_W = 8;
  localparam logic [5:0] FREQ_OFFSET_COMP_CONFIG_ADDR = 6'h19;
  localparam logic [5:0] BIT_SYNC_CONFIG_ADDR = 6'h1A;
  // Writable bits of each register
  localparam logic [7:0] FREQ_OFFSET_COMP_CONFIG_MASK = 8'h3F;
  localparam logic [7:0] BIT_SYNC_CONFIG_MASK = 8'hFF;
  localparam logic [7:0] FREQ_OFFSET_COMP_CONFIG_RST = 8'h36;
  localparam logic [7:0] BIT_SYNC_CONFIG_RST = 8'h6C;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;
  // Frequency offset compensation configuration fields
  localparam int unsigned LOOP_FREEZE_UNTIL_CARRIER_BIT = 5;
  localparam int unsigned FREQ_GAIN_BEFORE_SYNC_LSB = 3;
  localparam int unsigned FREQ_GAIN_AFTER_SYNC_BIT = 2;
  localparam int unsigned FREQ_OFFSET_SATURATION_LSB = 0;
  // Bit sync configuration fields
  localparam int unsigned CLKREC_INTEGRAL_BEFORE_SYNC_LSB = 6;
  localparam int unsigned CLKREC_PROPORTIONAL_BEFORE_SYNC_LSB = 4;
  localparam int unsigned CLKREC_INTEGRAL_AFTER_SYNC_BIT = 3;
  // Gains are expressed in units of half the base gain
  localparam int unsigned GAIN_W = 4;
  localparam logic [3:0] GAIN_HALF = 4'h1;
  // Saturation code to channel_bandwidth right shift
  localparam logic [1:0] SAT_OFF = 2'h0;
  localparam logic [1:0] SAT_SHIFT_CODE1 = 2'h3;
  localparam logic [1:0] SAT_SHIFT_CODE2 = 2'h2;
  localparam logic [1:0] SAT_SHIFT_CODE3 = 2'h1;
endpackage : dlg_pkg

// ### testbench/dlg_loop_config_assertions.sv
// Checker: port relations of the loop gain configuration block
`timescale 1ns/1ps
module dlg_loop_config_assertions
  import dlg_pkg::*;
(
  input wire logic clk_i, rst_n_i, reg_wr_i, reg_rd_i, rx_start_i, sync_match_i, carrier_sense_i,
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic [DATA_W-1:0] reg_wdata_i, reg_rdata_o,
  input wire logic loops_frozen_o, after_sync_o, freq_comp_enable_o,
  input wire logic [GAIN_W-1:0] freq_gain_o, clkrec_integral_gain_o, clkrec_proportional_gain_o,
  input wire logic [1:0] freq_limit_shift_o, bit_sync_low_bits_o
);
  logic [7:0] wd;
  logic w19, w1a;
  // Write data kept one cycle so a write can be tied to its effect
  always_ff @(posedge clk_i) wd <= reg_wdata_i;
  assign w19 = reg_wr_i && reg_addr_i == FREQ_OFFSET_COMP_CONFIG_ADDR;
  assign w1a = reg_wr_i && reg_addr_i == BIT_SYNC_CONFIG_ADDR;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  AST_FROZEN: assert property (loops_frozen_o |-> !carrier_sense_i) else $error("frozen");
  AST_FGAIN: assert property (w19 |=> after_sync_o || freq_gain_o == {1'b0, wd[4:3], 1'b0} + 4'h2)
    else $error("pre gain");
  AST_FPOST: assert property (w19 && reg_wdata_i[2] |=> !after_sync_o || freq_gain_o == GAIN_HALF)
    else $error("post gain");
  AST_LIMIT: assert property (w19 |=> freq_limit_shift_o == 2'h0 - wd[1:0]
    && freq_comp_enable_o == |wd[1:0]) else $error("limit");
  AST_KI: assert property (w1a |=> after_sync_o || clkrec_integral_gain_o == {1'b0, wd[7:6], 1'b0}
    + 4'h2) else $error("ki pre");
  AST_KP: assert property (w1a |=> clkrec_proportional_gain_o == {1'b0, wd[5:4], 1'b0} + 4'h2)
    else $error("kp");
  AST_KIPOST: assert property (w1a && reg_wdata_i[3] |=> !after_sync_o
    || clkrec_integral_gain_o == GAIN_HALF) else $error("ki post");
  AST_UPPER: assert property (reg_rd_i && reg_addr_i == FREQ_OFFSET_COMP_CONFIG_ADDR
    |=> reg_rdata_o[7:6] == 2'h0) else $error("upper bits");
  AST_SYNC: assert property (sync_match_i |-> after_sync_o) else $error("sync");
  AST_STAY: assert property (after_sync_o && !rx_start_i |=> after_sync_o) else $error("stay");
  AST_REVERT: assert property (rx_start_i && !sync_match_i |=> after_sync_o == sync_match_i)
    else $error("revert");
  cover property (sync_match_i);
  cover property (rx_start_i ##1 carrier_sense_i);
  cover property (w19 ##1 reg_rd_i);
endmodule : dlg_loop_config_assertions
bind dlg_loop_config dlg_loop_config_assertions u_chk (.*);

// ### testbench/test_demod_loop_gain_config.sv
// Testbench: random register settings checked against a bench model
`timescale 1ns/1ps
module test_demod_loop_gain_config;
  import dlg_pkg::*;
  logic clk_i = 0, rst_n_i = 0, reg_wr_i = 0, reg_rd_i = 0;
  logic rx_start_i = 0, sync_match_i = 0, carrier_sense_i = 0;
  logic [5:0] reg_addr_i = 0;
  logic [7:0] reg_wdata_i = 0, reg_rdata_o, m19 = 8'h36, m1a = 8'h6C;
  logic loops_frozen_o, after_sync_o, freq_comp_enable_o;
  logic [3:0] freq_gain_o, clkrec_integral_gain_o, clkrec_proportional_gain_o;
  logic [1:0] freq_limit_shift_o, bit_sync_low_bits_o;
  int failures = 0, checked = 0, i;
  integer seed = 32'hc64c75c5;
  dlg_loop_config u_dlg_loop_config (.*);
  always #2.5 clk_i = ~clk_i;
  function automatic logic [7:0] gn(input logic [1:0] c, input logic p, input logic a);
    return (a && p) ? 8'h01 : 8'((c + 1) * 2);
  endfunction : gn
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task automatic acc(input logic w, input logic [5:0] a, input logic [7:0] d);
    @(negedge clk_i) {reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i} = {w, !w, a, d};
    @(negedge clk_i) {reg_wr_i, reg_rd_i} = 2'b00;
  endtask : acc
  task automatic outs(input logic a);
    #1 chk("fgain", gn(m19[4:3], m19[2], a), freq_gain_o);
    chk("ki", gn(m1a[7:6], m1a[3], a), clkrec_integral_gain_o);
    chk("kp", gn(m1a[5:4], 1'b0, 1'b0), clkrec_proportional_gain_o);
    chk("limit", {m19[1:0] != 0, 2'h0 - m19[1:0]}, {freq_comp_enable_o, freq_limit_shift_o});
    chk("low", m1a[1:0], bit_sync_low_bits_o);
    chk("after", a, after_sync_o);
  endtask : outs
  task automatic summarize;
    $display("checked=%0d failures=%0d", checked, failures);
    if (failures == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : summarize
  initial begin
    #60000 failures++;
    summarize();
  end
  initial begin
    repeat (2) @(negedge clk_i);
    rst_n_i = 1;
    outs(0);
    for (i = 0; i < 30; i++) begin
      acc(0, FREQ_OFFSET_COMP_CONFIG_ADDR, 0);
      chk("rd19", m19, reg_rdata_o);
      acc(0, BIT_SYNC_CONFIG_ADDR, 0);
      chk("rd1a", m1a, reg_rdata_o);
      acc(0, 6'h05, 0);
      chk("unmapped", UNMAPPED_READ, reg_rdata_o);
      m19 = $random(seed);
      m1a = $random(seed);
      // Gain bits get random codes; limit zero appears as software would leave it for ASK
      acc(1, FREQ_OFFSET_COMP_CONFIG_ADDR, m19);
      acc(1, BIT_SYNC_CONFIG_ADDR, m1a);
      acc(1, 6'h05, 8'hFF);
      m19 &= 8'h3F;
      @(negedge clk_i) rx_start_i = 1;
      @(negedge clk_i) rx_start_i = 0;
      outs(0);
      chk("frozen", m19[5], loops_frozen_o);
      carrier_sense_i = 1;
      #1 chk("frozen", 0, loops_frozen_o);
      @(negedge clk_i) carrier_sense_i = 0;
      #1 chk("frozen", 0, loops_frozen_o);
      sync_match_i = 1;
      outs(1);
      @(negedge clk_i) sync_match_i = 0;
      outs(1);
      @(negedge clk_i) rx_start_i = 1;
      @(negedge clk_i) rx_start_i = 0;
      outs(0);
      // Start and match together: the match wins
      @(negedge clk_i) {rx_start_i, sync_match_i} = 2'b11;
      #1 chk("after", 1, after_sync_o);
      @(negedge clk_i) {rx_start_i, sync_match_i} = 2'b00;
      outs(1);
    end
    summarize();
  end
endmodule : test_demod_loop_gain_config
